// File: verilog/smsp_pkg.sv
package smsp_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [29:0] IDX_STATUS  = 30'h0000_002f;
  localparam logic [29:0] IDX_CONTROL = 30'h0000_0030;
  localparam logic [29:0] IDX_DATA    = 30'h0000_0031;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTL_IRQ_EN  = 7;
  localparam int CTL_ENABLE  = 6;
  localparam int CTL_LSB     = 5;
  localparam int CTL_MASTER  = 4;
  localparam int CTL_CLOCK_POLARITY    = 3;
  localparam int CTL_CLOCK_PHASE    = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  localparam int STS_DONE    = 7;
  localparam int STS_WRITE_COLLISION_FLAG    = 6;
  localparam int STS_DOUBLE  = 0;

  // ****************************************************************
  // Half periods of the master clock, indexed by {double, rate}.
  // ****************************************************************
  localparam logic [6:0] HALF_PERIOD [0:7] = '{
    7'h02,  // divide by 4
    7'h08,  // divide by 16
    7'h20,  // divide by 64
    7'h40,  // divide by 128
    7'h01,  // divide by 2
    7'h04,  // divide by 8
    7'h10,  // divide by 32
    7'h20   // divide by 64
  };

  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] LAST_BIT  = 3'h7;

  typedef struct packed {
    logic [7:0] ctrl;
    logic       dbl;
    logic       tdf;
    logic       write_collision_flag;
    logic       arm_tdf;
    logic       arm_write_collision_flag;
    logic [7:0] shift;
    logic [7:0] rxbuf;
    logic [2:0] bitcnt;
    logic [3:0] edge_cnt;
    logic       busy;
    logic       sck;
    logic [6:0] div_cnt;
    logic       out_bit;
    logic       sck_prev;
    logic       ss_prev;
    logic       dph_wr;
    logic [29:0] dph_idx;
    logic [7:0] rdata;
  } smsp_state_s;

endpackage : smsp_pkg

// File: verilog/smsp_port.sv
`timescale 1ns/1ns
module smsp_port (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // CPU side
  input  wire logic        global_irq_en,
  input  wire logic        irq_vector_ack,
  output logic             irq_req,
  // Pin direction choices made by software outside the port
  input  wire logic        ss_is_output,
  input  wire logic        mosi_user_out,
  input  wire logic        miso_user_out,
  input  wire logic        sck_user_out,
  // Serial pins
  input  wire logic        ss_n_in,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe
);

  smsp_pkg::smsp_state_s q;
  smsp_pkg::smsp_state_s d;

  logic       enabled;
  logic       master;
  logic       clock_polarity;
  logic       clock_phase;
  logic       lsb;
  logic       accept;
  logic       rd_status;
  logic       rd_data;
  logic       wr_data;
  logic       data_access;
  logic       mode_fault;
  logic       slave_sel;
  logic       done_evt;
  logic       sample_evt;
  logic       setup_evt;
  logic       in_bit;
  logic       top_bit;
  logic [7:0] shifted;
  logic [6:0] half;
  logic [29:0] word_idx;

  assign enabled  = q.ctrl[smsp_pkg::CTL_ENABLE];
  assign master   = q.ctrl[smsp_pkg::CTL_MASTER];
  assign clock_polarity     = q.ctrl[smsp_pkg::CTL_CLOCK_POLARITY];
  assign clock_phase     = q.ctrl[smsp_pkg::CTL_CLOCK_PHASE];
  assign lsb      = q.ctrl[smsp_pkg::CTL_LSB];
  assign word_idx = haddr[31:2];
  assign accept   = hsel && htrans[1] && hready;
  assign rd_status = accept && !hwrite && (word_idx == smsp_pkg::IDX_STATUS);
  assign rd_data   = accept && !hwrite && (word_idx == smsp_pkg::IDX_DATA);
  assign wr_data   = q.dph_wr && (q.dph_idx == smsp_pkg::IDX_DATA);
  assign data_access = rd_data || wr_data;
  // Mode fault only when select is an input.
  // select as output
  assign mode_fault = enabled && master && !ss_is_output && !ss_n_in;
  assign slave_sel  = enabled && !master && !ss_n_in;
  assign in_bit     = master ? miso_in : mosi_in;
  assign top_bit    = lsb ? q.shift[0] : q.shift[7];
  assign shifted    = lsb ? {in_bit, q.shift[7:1]} : {q.shift[6:0], in_bit};
  assign half = smsp_pkg::HALF_PERIOD[{q.dbl, q.ctrl[smsp_pkg::CTL_RATE_HI],
                                       q.ctrl[smsp_pkg::CTL_RATE_LO]}];

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    d          = q;
    done_evt   = 1'b0;
    sample_evt = 1'b0;
    setup_evt  = 1'b0;
    d.sck_prev = sck_in;
    d.ss_prev  = ss_n_in;
    d.dph_wr   = 1'b0;
    if (accept) begin
      d.dph_wr  = hwrite;
      d.dph_idx = word_idx;
      d.rdata   = 8'h00;
      if (word_idx == smsp_pkg::IDX_STATUS) begin
        d.rdata = {q.tdf, q.write_collision_flag, 5'h00, q.dbl};
      end else if (word_idx == smsp_pkg::IDX_CONTROL) begin
        d.rdata = q.ctrl;
      end else if (word_idx == smsp_pkg::IDX_DATA) begin
        d.rdata = q.rxbuf;
      end
    end
    if (!q.busy) begin
      d.out_bit = top_bit;
      d.sck     = clock_polarity;
    end

    // Serial engine. A disabled port holds everything idle.
    // enable gate
    if (!enabled) begin
      d.busy     = 1'b0;
      d.bitcnt   = 3'h0;
      d.edge_cnt = 4'h0;
      d.div_cnt  = 7'h00;
    end else if (master) begin
      if (q.busy) begin
        if (q.div_cnt == half - 7'h01) begin
          d.div_cnt  = 7'h00;
          d.sck      = !q.sck;
          d.edge_cnt = q.edge_cnt + 4'h1;
          sample_evt = (q.edge_cnt[0] == clock_phase);
          setup_evt  = !sample_evt;
          if (q.edge_cnt == smsp_pkg::LAST_EDGE) begin
            d.busy = 1'b0;
          end
        end else begin
          d.div_cnt = q.div_cnt + 7'h01;
        end
      end
    end else if (!ss_n_in) begin
      if (sck_in != q.sck_prev) begin
        d.busy     = 1'b1;
        sample_evt = ((sck_in != clock_polarity) != clock_phase);
        setup_evt  = !sample_evt;
      end
    end else begin
      d.busy   = 1'b0;
      d.bitcnt = 3'h0;
    end

    if (setup_evt) begin
      d.out_bit = top_bit;
    end
    if (sample_evt) begin
      d.shift  = shifted;
      d.bitcnt = q.bitcnt + 3'h1;
      if (q.bitcnt == smsp_pkg::LAST_BIT) begin
        d.rxbuf  = shifted;
        done_evt = 1'b1;
        if (!master) begin
          d.busy = 1'b0;
        end
      end
    end

    if (enabled && !master && ss_n_in && !q.ss_prev) begin
      d.busy   = 1'b0;
      d.bitcnt = 3'h0;
      d.shift  = 8'h00;
    end

    // Register writes in the data phase.
    if (q.dph_wr && q.dph_idx == smsp_pkg::IDX_CONTROL) begin
      d.ctrl = hwdata[7:0];
    end
    if (q.dph_wr && q.dph_idx == smsp_pkg::IDX_STATUS) begin
      d.dbl = hwdata[smsp_pkg::STS_DOUBLE];
    end
    if (wr_data) begin
      if (q.busy) begin
        d.write_collision_flag = 1'b1;
      end else begin
        d.shift    = hwdata[7:0];
        d.out_bit  = lsb ? hwdata[0] : hwdata[7];
        d.bitcnt   = 3'h0;
        d.edge_cnt = 4'h0;
        d.div_cnt  = 7'h00;
        d.busy     = enabled && master;
      end
    end

    if (mode_fault) begin
      d.ctrl[smsp_pkg::CTL_MASTER] = 1'b0;
      d.busy     = 1'b0;
      d.bitcnt   = 3'h0;
      d.edge_cnt = 4'h0;
      d.sck      = clock_polarity;
    end

    // Flag clearing by the status-then-data sequence; a set in the
    // same cycle wins so no completion is lost.
    if (rd_status) begin
      d.arm_tdf  = q.tdf;
      d.arm_write_collision_flag = q.write_collision_flag;
    end
    if (data_access) begin
      if (q.arm_tdf || q.arm_write_collision_flag) begin
        d.tdf = 1'b0;
      end
      if (q.arm_write_collision_flag && !(wr_data && q.busy)) begin
        d.write_collision_flag = 1'b0;
      end
      d.arm_tdf  = 1'b0;
      d.arm_write_collision_flag = 1'b0;
    end
    if (irq_vector_ack) begin
      d.tdf = 1'b0;
    end
    if (done_evt || mode_fault) begin
      d.tdf = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q       <= '0;
      q.ctrl  <= smsp_pkg::CONTROL_RESET;
      q.sck   <= 1'b0;
      q.ss_prev <= 1'b1;
      q.sck_prev <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign hrdata    = {24'h00_0000, q.rdata};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq_req   = q.ctrl[smsp_pkg::CTL_IRQ_EN] && q.tdf && global_irq_en;
  assign sck_out   = q.sck;
  assign mosi_out  = q.out_bit;
  assign miso_out  = q.out_bit;
  // Master pins drop to inputs the same cycle the fault clears master.
  assign mosi_oe   = enabled && master && mosi_user_out;
  assign sck_oe    = enabled && master && sck_user_out;
  assign miso_oe   = slave_sel && miso_user_out;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  sequence s_stat_write_collision_flag_read;
    rd_status && q.write_collision_flag;
  endsequence

  sequence s_data_touch;
    data_access && !(wr_data && q.busy) && !done_evt && !mode_fault;
  endsequence

  property p_passive;
    @(posedge sys_clk) disable iff (!rstn)
      (!master && ss_n_in) |-> !miso_oe;
  endproperty
  a_passive: assert property (p_passive) else $error("slave drives while deselected");

  property p_ss_reset;
    @(posedge sys_clk) disable iff (!rstn)
      (enabled && !master && ss_n_in && !q.ss_prev && !wr_data) |=>
        (!q.busy && q.bitcnt == 3'h0 && q.shift == 8'h00);
  endproperty
  a_ss_reset: assert property (p_ss_reset) else $error("select rise did not reset");

  property p_fault;
    @(posedge sys_clk) disable iff (!rstn)
      mode_fault |=> (!master && q.tdf && !q.busy);
  endproperty
  a_fault: assert property (p_fault) else $error("mode fault not handled");

  property p_idle_level;
    @(posedge sys_clk) disable iff (!rstn)
      ($past(!q.busy) && $stable(clock_polarity)) |-> (q.sck == clock_polarity);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

  property p_enable;
    @(posedge sys_clk) disable iff (!rstn)
      (!enabled && !wr_data) |=> !q.busy;
  endproperty
  a_enable: assert property (p_enable) else $error("busy while disabled");

  property p_fast_clock;
    @(posedge sys_clk) disable iff (!rstn)
      (master && q.busy && half == 7'h01 && q.edge_cnt != 4'h0 && !mode_fault
       && !wr_data && $stable(q.ctrl)) |=> ($changed(q.sck) || !q.busy);
  endproperty
  a_fast_clock: assert property (p_fast_clock) else $error("double speed clock wrong");

  property p_collision;
    @(posedge sys_clk) disable iff (!rstn)
      (wr_data && q.busy && !sample_evt) |=> (q.write_collision_flag && $stable(q.shift) || !master);
  endproperty
  a_collision: assert property (p_collision) else $error("collision not flagged");

  property p_both_clear;
    @(posedge sys_clk) disable iff (!rstn)
      s_stat_write_collision_flag_read ##2 s_data_touch |=> (!q.write_collision_flag && !q.tdf);
  endproperty
  a_both_clear: assert property (p_both_clear) else $error("flags not cleared");

  property p_reserved;
    @(posedge sys_clk) disable iff (!rstn)
      rd_status |=> (hrdata[5:1] == 5'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_one_byte;
    @(posedge sys_clk) disable iff (!rstn)
      (master && q.busy && q.edge_cnt == smsp_pkg::LAST_EDGE && q.div_cnt == half - 7'h01
       && !mode_fault && !wr_data && $stable(q.ctrl)) |=> !q.busy;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("clock ran past one byte");

  property p_done_buffer;
    @(posedge sys_clk) disable iff (!rstn)
      done_evt |=> (q.tdf && q.rxbuf == $past(shifted));
  endproperty
  a_done_buffer: assert property (p_done_buffer) else $error("byte not buffered");

endmodule : smsp_port

// File: test/smsp_remote.sv
`timescale 1ns/1ns
// ******************************************************
// Remote serial slave facing the port in master mode.
// ******************************************************
module smsp_remote (
  // Clock
  input  wire logic       sys_clk,
  // Serial pins
  input  wire logic       sel_n,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Format and data
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx
);
  logic       sck_q;
  logic       lead;
  logic       last = 1'b0;
  logic [2:0] pos;
  logic [3:0] n;

  assign lead = (sck != clock_polarity);
  // An unselected remote drives the inverse of its last bit, so a stale sample shows up.
  assign miso = sel_n ? ~last : (lsb ? tx[pos] : tx[3'h7 - pos]);

  always @(posedge sys_clk) begin
    sck_q <= sck;
    if (!sel_n)
      last <= miso;
    if (sel_n) begin
      pos <= 3'h0;
      n   <= 4'h0;
    end else if (sck != sck_q) begin
      n <= n + 4'h1;
      if (lead != clock_phase)
        rx <= lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      else if (!(clock_phase && n == 4'h0))
        pos <= pos + 3'h1;
    end
  end
endmodule : smsp_remote

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
  // ******************************************************
  // Bus master, pin wiring and scenarios for the port.
  // ******************************************************
  localparam logic [31:0] a_sts = {smsp_pkg::IDX_STATUS, 2'b00};
  localparam logic [31:0] a_ctl = {smsp_pkg::IDX_CONTROL, 2'b00};
  localparam logic [31:0] a_dat = {smsp_pkg::IDX_DATA, 2'b00};
  localparam int          half_exp [8] = '{2, 8, 32, 64, 1, 4, 16, 32};

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        glb_ie = 1'b0;
  logic        vec_ack = 1'b0;
  logic        ss_out = 1'b1;
  logic        ss_n = 1'b1;
  logic        ext_sck = 1'b0;
  logic        ext_mosi = 1'b0;
  logic        rem_sel_n = 1'b1;
  logic [7:0]  rem_tx = 8'h00;
  logic [7:0]  ctl = 8'h00;
  logic        dbl = 1'b0;
  logic [7:0]  rem_rx, r8;
  logic [31:0] rd, hrdata;
  logic        hreadyout, hresp, irq_req, sck_q, rem_miso;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic        sck_pin, mosi_pin, miso_pin;
  int          fails = 0;
  int          tests_run = 0;
  int          toggles = 0;
  int          run = 0;
  int          half_seen = 0;
  int          m;

  assign sck_pin  = sck_oe ? sck_out : ext_sck;
  assign mosi_pin = mosi_oe ? mosi_out : ext_mosi;
  assign miso_pin = miso_oe ? miso_out : rem_miso;

  initial forever #2 sys_clk = ~sys_clk;

  // Counts clock edges and the length of the last clock phase.
  always @(posedge sys_clk) begin
    sck_q <= sck_out;
    if (sck_out !== sck_q) begin
      toggles   <= toggles + 1;
      half_seen <= run;
      run       <= 1;
    end else begin
      run <= run + 1;
    end
  end

  smsp_port u_smsp_port (
    .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .global_irq_en(glb_ie),
    .irq_vector_ack(vec_ack), .irq_req(irq_req), .ss_is_output(ss_out),
    .mosi_user_out(1'b1), .miso_user_out(1'b1), .sck_user_out(1'b1),
    .ss_n_in(ss_n), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe),
    .mosi_in(mosi_pin), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_pin), .miso_out(miso_out), .miso_oe(miso_oe)
  );

  smsp_remote u_smsp_remote (
    .sys_clk(sys_clk), .sel_n(rem_sel_n), .sck(sck_pin), .mosi(mosi_pin),
    .miso(rem_miso), .clock_polarity(ctl[3]), .clock_phase(ctl[2]), .lsb(ctl[5]), .tx(rem_tx),
    .rx(rem_rx)
  );

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic timeout(input string what);
    fails++;
    $display("mismatch at %0t: no answer for %s", $time, what);
    stop_test();
  endtask : timeout

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100)
      timeout("bus");
  endtask : bus

  task automatic set_ctl(input logic [7:0] v);
    ctl <= v;
    bus(a_ctl, 1'b1, {24'h0, v});
  endtask : set_ctl

  task automatic wait_done;
    for (int i = 0; i < 2000; i++) begin
      bus(a_sts, 1'b0, 32'h0);
      if (rd[7] === 1'b1)
        return;
    end
    timeout("done flag");
  endtask : wait_done

  task automatic xfer(input logic [7:0] dv, input logic [7:0] rv, input logic full);
    int base;
    // A new polarity moves the idle clock once; keep that out of the count.
    repeat (3) @(posedge sys_clk);
    base = toggles;
    rem_tx    <= rv;
    rem_sel_n <= 1'b0;
    bus(a_dat, 1'b1, {24'h0, dv});
    wait_done();
    for (int i = 0; i < 3000 && toggles - base < 16; i++)
      @(posedge sys_clk);
    // A long quiet stretch shows the generator really stopped.
    repeat (300) @(posedge sys_clk);
    check(toggles - base, 16, "edges");
    if (full) check(rem_rx, dv, "remote rx");
    bus(a_dat, 1'b0, 32'h0);
    if (full) check(rd, rv, "data rx");
    bus(a_sts, 1'b0, 32'h0);
    check(rd, {31'h0, dbl}, "flag clear");
    rem_sel_n <= 1'b1;
    @(posedge sys_clk);
  endtask : xfer

  task automatic ext(input logic [7:0] tx, input int bits, input logic sel);
    logic [7:0] s;
    s  = tx;
    r8 = 8'h00;
    ss_n     <= ~sel;
    ext_mosi <= s[7];
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < bits; i++) begin
      r8 = {r8[6:0], miso_pin};
      ext_sck <= 1'b1;
      repeat (4) @(posedge sys_clk);
      s = s << 1;
      ext_sck  <= 1'b0;
      ext_mosi <= s[7];
      repeat (4) @(posedge sys_clk);
    end
  endtask : ext

  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    bus(a_ctl, 1'b0, 32'h0);
    check(rd, 32'h0, "control reset");
    check(hresp, 1'b0, "okay response");
    bus(a_sts, 1'b0, 32'h0);
    check(rd, 32'h0, "status reset");
    bus(32'h0000_0010, 1'b1, 32'h0000_00ff);
    bus(32'h0000_0010, 1'b0, 32'h0);
    check(rd, 32'h0, "unmapped");
    set_ctl(8'haf);
    bus(a_ctl, 1'b0, 32'h0);
    check(rd, 32'h0000_00af, "control rw");
    bus(a_sts, 1'b1, 32'h0000_00ff);
    bus(a_sts, 1'b0, 32'h0);
    check(rd, 32'h0000_0001, "status rw");
    bus(a_sts, 1'b1, 32'h0);
    $display("test registers done");
    for (m = 0; m < 8; m++) begin
      set_ctl({2'b01, m[2], 1'b1, m[1:0], 2'b00});
      xfer(8'h4d ^ m[7:0], 8'hb2 + m[7:0], 1'b1);
      check(sck_out, ctl[3], "idle level");
    end
    $display("test formats done");
    for (m = 0; m < 8; m++) begin
      dbl = m[2];
      bus(a_sts, 1'b1, {31'h0, dbl});
      set_ctl({6'b010100, m[1:0]});
      xfer(8'h96, 8'h69, m != 4);
      check(half_seen, half_exp[m], "half period");
    end
    dbl = 1'b0;
    bus(a_sts, 1'b1, 32'h0);
    $display("test dividers done");
    rem_sel_n <= 1'b0;
    bus(a_dat, 1'b1, 32'h0000_0011);
    bus(a_dat, 1'b1, 32'h0000_0022);
    wait_done();
    // The last trailing edge is still due; let the generator stop first.
    repeat (150) @(posedge sys_clk);
    bus(a_sts, 1'b0, 32'h0);
    check(rd, 32'h0000_00c0, "collision");
    check(rem_rx, 8'h11, "first byte");
    bus(a_dat, 1'b0, 32'h0);
    bus(a_sts, 1'b0, 32'h0);
    check(rd, 32'h0, "both cleared");
    rem_sel_n <= 1'b1;
    $display("test collision done");
    glb_ie <= 1'b1;
    set_ctl(8'hd0);
    bus(a_dat, 1'b1, 32'h0000_0033);
    wait_done();
    check(irq_req, 1'b1, "irq on");
    glb_ie <= 1'b0;
    @(posedge sys_clk);
    check(irq_req, 1'b0, "irq masked");
    vec_ack <= 1'b1;
    @(posedge sys_clk);
    vec_ack <= 1'b0;
    @(posedge sys_clk);
    bus(a_sts, 1'b0, 32'h0);
    check(rd, 32'h0, "vector clear");
    $display("test interrupt done");
    glb_ie <= 1'b1;
    ss_n   <= 1'b0;
    repeat (4) @(posedge sys_clk);
    bus(a_ctl, 1'b0, 32'h0);
    check(rd, 32'h0000_00d0, "select as output");
    ss_out <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(irq_req, 1'b1, "fault irq");
    check({sck_oe, mosi_oe}, 2'b00, "pins released");
    bus(a_ctl, 1'b0, 32'h0);
    check(rd, 32'h0000_00c0, "master cleared");
    bus(a_sts, 1'b0, 32'h0);
    check(rd, 32'h0000_0080, "fault done");
    bus(a_dat, 1'b0, 32'h0);
    glb_ie <= 1'b0;
    ss_n   <= 1'b1;
    ss_out <= 1'b1;
    set_ctl(8'h50);
    xfer(8'hc3, 8'h3c, 1'b1);
    set_ctl(8'h10);
    m = toggles;
    bus(a_dat, 1'b1, 32'h0000_0055);
    repeat (100) @(posedge sys_clk);
    check(toggles - m, 0, "disabled");
    $display("test mode fault done");
    ss_out <= 1'b0;
    set_ctl(8'h43);
    bus(a_dat, 1'b1, 32'h0000_00a5);
    ext(8'h3c, 8, 1'b1);
    check(r8, 8'ha5, "slave sent");
    check(miso_oe, 1'b1, "slave drives");
    wait_done();
    bus(a_dat, 1'b0, 32'h0);
    check(rd, 32'h0000_003c, "slave rx");
    ss_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check(miso_oe, 1'b0, "slave idle");
    ext(8'hff, 3, 1'b1);
    ss_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ext(8'h5a, 8, 1'b1);
    wait_done();
    bus(a_dat, 1'b0, 32'h0);
    check(rd, 32'h0000_005a, "resync");
    ss_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ext(8'h77, 8, 1'b0);
    bus(a_sts, 1'b0, 32'h0);
    check(rd, 32'h0, "passive");
    $display("test slave done");
    stop_test();
  end
endmodule : testbench
